// ===== apl_key.sv
/*
 * unlock key sequencer.
 * assumes every completed bus access is presented as one acc pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module apl_key
    import apl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // access strobe
    apl_wr_if.key w
);
    apl_key_t state_q;

    // two ordered key writes open the gate for exactly the next access
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= APL_IDLE;
        end else if (w.acc) begin
            unique case (state_q)
                APL_IDLE: state_q <= (w.wr && w.addr == APL_OFS_KEY && w.wdata[7:0] == APL_KEY1)
                    ? APL_GOT1 : APL_IDLE;
                APL_GOT1: state_q <= (w.wr && w.addr == APL_OFS_KEY && w.wdata[7:0] == APL_KEY2)
                    ? APL_OPEN : APL_IDLE;
                APL_OPEN: state_q <= APL_IDLE; // any access consumes the gate
            endcase
        end
    end
    assign w.open = (state_q == APL_OPEN);

    seq_abort_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_q == APL_GOT1 && w.acc && !(w.wr && w.addr == APL_OFS_KEY))
        |=> state_q == APL_IDLE) else $error("unlock not aborted");
endmodule
`default_nettype wire

// ===== apl_pkg.sv
/*
 * constants for the arbitration priority lock register bank.
 * assumes an apb slave with 32-bit data, one aligned word per register.
 */
// Overview of operation
// - the dma channel 2 priority is a writable 3-bit field in bits 2..0, reset to 011, bits 7..3 read zero.
// - the scanner priority is a writable 3-bit field in bits 2..0, reset to 100, bits 7..3 read zero.
// - the lock register holds only the lock flag in bit 0, reset to zero, bits 7..1 read zero.
// - with the lock flag clear, software writes to the priority registers are accepted.
// - with the lock flag set, software writes to the priority registers are ignored.
// - the lock flag changes only on a write that directly follows a completed unlock sequence.
// - with the one-way option set, the lock flag cannot be cleared once set, even after unlocking.
// - a reset clears the lock flag and re-arms the one-way behaviour for one more set; the code also resets the one-way option to zero.
package apl_pkg;
    localparam logic [11:0] APL_OFS_DMA2 = 12'h000;
    localparam logic [11:0] APL_OFS_SCAN = 12'h004;
    localparam logic [11:0] APL_OFS_LOCK = 12'h008;
    localparam logic [11:0] APL_OFS_KEY = 12'h00c;
    localparam logic [11:0] APL_OFS_CFG = 12'h010;
    localparam logic [2:0] APL_DMA2_RST = 3'h3;
    localparam logic [2:0] APL_SCAN_RST = 3'h4;
    localparam logic APL_LOCK_RST = 1'b0;
    localparam logic APL_ONEWAY_RST = 1'b0;
    localparam int APL_PRI_LSB = 0;
    localparam int APL_LOCK_BIT = 0;
    localparam logic [7:0] APL_KEY1 = 8'h55;
    localparam logic [7:0] APL_KEY2 = 8'haa;
    typedef enum logic [1:0] {APL_IDLE, APL_GOT1, APL_OPEN} apl_key_t;
endpackage

// ===== apl_top.sv
/*
 * arbitration priority registers with lock, reached over apb.
 * holds the dma channel 2 and scanner priority fields, the lock flag, the key
 * port that opens the lock for one write, and the one-way option.
 * every access takes one setup and one access cycle; read data and the error
 * response are registered at setup so they stand for the whole access phase.
 * assumes the arbiter outside reads the priority and lock outputs.
 * assumes the apb master is on core_clk, so no input is synchronised.
 * assumes boot code writes the one-way option again after every reset, as the
 * option itself returns to zero with the rest of the bank.
 */
`timescale 1ns/1ps
`default_nettype none
module apl_top
    import apl_pkg::*;
#(
    parameter int PRI_W = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // to the arbiter
    output logic [PRI_W-1:0] dma2_pri,
    output logic [PRI_W-1:0] scan_pri,
    output logic pri_locked
);
    apl_wr_if w();
    logic [PRI_W-1:0] dma2_q, scan_q;
    logic lock_q, oneway_q, ack_q;
    logic setup, acc, wr, mapped;
    logic [31:0] rd_d, prdata_q;
    logic pslverr_q;

    // accesses complete in the cycle after setup
    assign setup = psel && !penable;
    assign acc = psel && penable && ack_q;
    assign wr = acc && pwrite;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == APL_OFS_DMA2) || (a == APL_OFS_SCAN) || (a == APL_OFS_LOCK)
            || (a == APL_OFS_KEY) || (a == APL_OFS_CFG);
    endfunction
    assign mapped = is_mapped(paddr);

    assign w.acc = acc;
    assign w.wr = pwrite;
    assign w.addr = paddr;
    assign w.wdata = pwdata;
    apl_key i_apl_key (.core_clk(core_clk), .reset_n(reset_n), .w(w));

    // one wait-free ready in the access phase
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= setup;
        end
    end
    assign pready = ack_q;

    // priority writes pass only while unlocked
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dma2_q <= APL_DMA2_RST;
            scan_q <= APL_SCAN_RST;
        end else if (wr && !lock_q) begin
            if (paddr == APL_OFS_DMA2) dma2_q <= pwdata[APL_PRI_LSB +: PRI_W];
            if (paddr == APL_OFS_SCAN) scan_q <= pwdata[APL_PRI_LSB +: PRI_W];
        end
    end

    // one-way option, writable only while the lock flag is clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oneway_q <= APL_ONEWAY_RST;
        end else if (wr && paddr == APL_OFS_CFG && !lock_q) begin
            oneway_q <= pwdata[0];
        end
    end

    // lock flag changes only straight after an unlock sequence
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= APL_LOCK_RST;
        end else if (wr && paddr == APL_OFS_LOCK && w.open) begin
            if (!(oneway_q && lock_q)) lock_q <= pwdata[APL_LOCK_BIT];
        end
    end

    // read mux, unimplemented bits zero
    always_comb begin
        rd_d = 32'h0;
        unique case (paddr)
            APL_OFS_DMA2: rd_d[PRI_W-1:0] = dma2_q;
            APL_OFS_SCAN: rd_d[PRI_W-1:0] = scan_q;
            APL_OFS_LOCK: rd_d[0] = lock_q;
            APL_OFS_CFG: rd_d[0] = oneway_q;
            default: rd_d = 32'h0;
        endcase
    end

    // read data and error captured at setup, so both outputs come from flops
    // and stand through the access phase; no write can land on the setup edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup && !mapped;
            if (setup) begin
                prdata_q <= rd_d;
            end
        end
    end
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign dma2_pri = dma2_q;
    assign scan_pri = scan_q;
    assign pri_locked = lock_q;

    // checks of the bus timing, the lock and the read paths

    // no priority moves while the lock flag is set
    locked_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        lock_q
        |=> $stable(dma2_q) && $stable(scan_q))
        else $error("locked priority changed");

    // an unlocked write to the dma channel 2 field lands
    unlocked_wr_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && !lock_q && paddr == APL_OFS_DMA2)
        |=> dma2_q == $past(pwdata[2:0]))
        else $error("unlocked write lost");

    // an unlocked write to the scanner field lands
    scan_wr_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && !lock_q && paddr == APL_OFS_SCAN)
        |=> scan_q == $past(pwdata[2:0]))
        else $error("unlocked scan write lost");

    // a locked write to the dma channel 2 field is dropped
    dma2_locked_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && lock_q && paddr == APL_OFS_DMA2)
        |=> $stable(dma2_q))
        else $error("locked dma write taken");

    // a locked write to the scanner field is dropped
    scan_locked_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && lock_q && paddr == APL_OFS_SCAN)
        |=> $stable(scan_q))
        else $error("locked scan write taken");

    // the lock flag moves only on a lock write through an open gate
    lock_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !(wr && paddr == APL_OFS_LOCK && w.open)
        |=> $stable(lock_q))
        else $error("lock changed without unlock");

    // a lock write through an open gate takes bit 0, unless one-way holds it
    lock_take_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && paddr == APL_OFS_LOCK && w.open && !(oneway_q && lock_q))
        |=> lock_q == $past(pwdata[0]))
        else $error("unlocked lock write lost");

    // with one-way set the flag never clears again
    oneway_keep_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (oneway_q && lock_q)
        |=> lock_q)
        else $error("one-way lock cleared");

    // after reset one set is still allowed, even with one-way chosen
    oneway_rearm_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (!lock_q && wr && paddr == APL_OFS_LOCK && w.open && pwdata[0])
        |=> lock_q)
        else $error("lock set refused");

    // the open gate is spent by the very next access
    gate_spent_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (w.open && acc)
        |=> !w.open)
        else $error("unlock gate reused");

    // the one-way option is frozen while locked
    cfg_locked_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        lock_q
        |=> $stable(oneway_q))
        else $error("option changed while locked");

    // key writes leave the priority fields alone
    key_wr_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && paddr == APL_OFS_KEY)
        |=> $stable(dma2_q) && $stable(scan_q))
        else $error("key write hit a priority");

    // writes to holes change nothing
    unmapped_wr_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr && !mapped)
        |=> $stable(dma2_q) && $stable(scan_q) && $stable(lock_q) && $stable(oneway_q))
        else $error("unmapped write took effect");

    // the unimplemented upper bits always read zero
    rd_zero_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        1'b1
        |-> prdata[31:3] == 29'h0)
        else $error("reserved bits nonzero");

    // dma channel 2 read data stands in the access phase
    dma2_rd_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && paddr == APL_OFS_DMA2)
        |=> prdata[31:3] == 29'h0 && prdata[2:0] == dma2_q)
        else $error("dma readback");

    // scanner read data stands in the access phase
    scan_rd_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && paddr == APL_OFS_SCAN)
        |=> prdata[31:3] == 29'h0 && prdata[2:0] == scan_q)
        else $error("scan readback");

    // lock read data holds only the flag
    lock_rd_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && paddr == APL_OFS_LOCK)
        |=> prdata == {31'h0, lock_q})
        else $error("lock readback");

    // reads of holes return zero
    unmapped_zero_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && !mapped)
        |=> prdata == 32'h0)
        else $error("unmapped read nonzero");

    // ready follows every setup cycle
    ready_next_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        setup
        |=> pready)
        else $error("ready missing after setup");

    // ready stands for one cycle only
    ready_pulse_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        pready
        |=> !pready)
        else $error("ready held too long");

    // an unmapped address answers with an error
    err_unmapped_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && !mapped)
        |=> pslverr && pready)
        else $error("error response missing");

    // a mapped address answers without an error
    err_mapped_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (setup && mapped)
        |=> !pslverr)
        else $error("spurious error response");

    // reset release leaves the lock flag and both priority fields at their reset values
    reset_rearm_a: assert property (
        @(posedge core_clk)
        $rose(reset_n)
        |-> !lock_q && dma2_q == APL_DMA2_RST && scan_q == APL_SCAN_RST)
        else $error("reset values");

    // main scenarios reached
    c_lock: cover property (@(posedge core_clk) $rose(lock_q));
    c_unlock: cover property (@(posedge core_clk) $fell(lock_q));
    c_blocked: cover property (@(posedge core_clk) wr && lock_q && paddr == APL_OFS_DMA2);
    c_refused: cover property (@(posedge core_clk) wr && paddr == APL_OFS_LOCK && !w.open);
    c_oneway: cover property (@(posedge core_clk) wr && paddr == APL_OFS_LOCK && w.open
        && oneway_q && lock_q && !pwdata[0]);
endmodule
`default_nettype wire

// ===== apl_wr_if.sv
/*
 * register access strobe with raw write, address and data between the bus slave and the key unit.
 * assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface apl_wr_if;
    logic acc; // one-cycle pulse per completed access
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic open; // unlock sequence complete
    modport bus (output acc, output wr, output addr, output wdata, input open);
    modport key (input acc, input wr, input addr, input wdata, output open);
endinterface
`default_nettype wire

// ===== arbitration_priority_lock_tb.sv
/* bench for apl_top: apb accesses to the priority and lock registers.
   assumes apl_pkg offsets and keys; drives all ports itself. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module arbitration_priority_lock_tb;
    import apl_pkg::*;
    logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, pri_locked;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] dma2_pri, scan_pri;
    int bad_count = 0;
    int checked = 0;
    apl_top #(.PRI_W(3)) i_apl_top (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma2_pri(dma2_pri),
        .scan_pri(scan_pri), .pri_locked(pri_locked));
    // clock source
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // wait as long as the slave takes; only the watchdog ends a hang
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // read and compare data and error response
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask
    task automatic unlock();
        wr(APL_OFS_KEY, {24'h0, APL_KEY1});
        wr(APL_OFS_KEY, {24'h0, APL_KEY2});
    endtask
    // summary and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #(40 * 2000);
        bad_count++;
        give_verdict();
    end
    // test sequence
    initial begin
        reset_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h0;
        pwdata <= 32'h0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        `CHK({dma2_pri, scan_pri, pri_locked}, 7'h38)
        rd(APL_OFS_DMA2, 32'h3, 1'b0);
        rd(APL_OFS_SCAN, 32'h4, 1'b0);
        rd(APL_OFS_LOCK, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        wr(APL_OFS_DMA2, 32'hffff_fffe);
        rd(APL_OFS_DMA2, 32'h6, 1'b0);
        wr(APL_OFS_SCAN, 32'h0000_00f9);
        rd(APL_OFS_SCAN, 32'h1, 1'b0);
        wr(APL_OFS_LOCK, 32'h1);
        rd(APL_OFS_LOCK, 32'h0, 1'b0);
        unlock();
        wr(APL_OFS_LOCK, 32'hffff_ffff);
        rd(APL_OFS_LOCK, 32'h1, 1'b0);
        wr(APL_OFS_DMA2, 32'h5);
        rd(APL_OFS_DMA2, 32'h6, 1'b0);
        `CHK({dma2_pri, pri_locked}, 4'hd)
        unlock();
        rd(APL_OFS_SCAN, 32'h1, 1'b0);
        wr(APL_OFS_LOCK, 32'h0);
        rd(APL_OFS_LOCK, 32'h1, 1'b0);
        wr(APL_OFS_KEY, {24'h0, APL_KEY1});
        rd(APL_OFS_SCAN, 32'h1, 1'b0);
        wr(APL_OFS_KEY, {24'h0, APL_KEY2});
        wr(APL_OFS_LOCK, 32'h0);
        rd(APL_OFS_LOCK, 32'h1, 1'b0);
        unlock();
        wr(APL_OFS_LOCK, 32'h0);
        rd(APL_OFS_LOCK, 32'h0, 1'b0);
        wr(APL_OFS_CFG, 32'h1);
        unlock();
        wr(APL_OFS_LOCK, 32'h1);
        unlock();
        wr(APL_OFS_LOCK, 32'h0);
        rd(APL_OFS_LOCK, 32'h1, 1'b0);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(APL_OFS_LOCK, 32'h0, 1'b0);
        rd(APL_OFS_DMA2, 32'h3, 1'b0);
        unlock();
        wr(APL_OFS_LOCK, 32'h1);
        rd(APL_OFS_LOCK, 32'h1, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
